// ===== design/uesf_consts.svh
/*
 * Constants of the USB error status flag block: register offsets, flag positions,
 * reset values and timing counts.
 * Assumes it is included by its bare name from design files.
 */
`ifndef UESF_CONSTS_SVH
`define UESF_CONSTS_SVH

// Register byte addresses on the APB bus.
`define UESF_OFF_STATUS 12'h000
`define UESF_OFF_MASK 12'h004
`define UESF_OFF_EVENT_RAW 12'h008
`define UESF_ADDR_W 12

// Flag positions within the status and mask registers.
`define UESF_BIT_PID 0
`define UESF_BIT_TOKEN_EOF 1
`define UESF_BIT_DATA_CRC 2
`define UESF_BIT_BYTE_ALIGN 3
`define UESF_BIT_TURNAROUND 4
`define UESF_BIT_MEM_ACCESS 5
`define UESF_BIT_BUS_MATRIX 6
`define UESF_BIT_BIT_STUFF 7
`define UESF_NFLAGS 8

// Reset values.
`define UESF_FLAGS_RST 8'h00
`define UESF_MASK_RST 8'h00
`define UESF_ZERO32 32'h0000_0000

// Turnaround idle limit in bit times and bit-time length in module clocks.
`define UESF_TURN_BIT_TIMES 16
`define UESF_BIT_CLKS 8
`define UESF_CNT_W 8
`define UESF_TURN_LIMIT ((`UESF_TURN_BIT_TIMES) * (`UESF_BIT_CLKS))
`define UESF_CNT_ONE 8'h01
`define UESF_CNT_ZERO 8'h00

`endif

// ===== design/uesf_pkg.sv
/*
 * Types of the USB error status flag block.
 * Assumes the constants header is on the include path.
 */
`include "uesf_consts.svh"

package uesf_pkg;
    typedef logic [`UESF_NFLAGS-1:0] uesf_flags_t;
    typedef logic [`UESF_CNT_W-1:0] uesf_cnt_t;

    // Turnaround watchdog states.
    typedef enum logic [2:0] {
        UESF_T_IDLE = 3'b001,
        UESF_T_WAIT = 3'b010,
        UESF_T_DONE = 3'b100
    } uesf_turn_t;
endpackage

// ===== design/uesf_sync.sv
/*
 * Two-flip-flop synchroniser for a group of level inputs.
 * Assumes the inputs are levels that stay for at least two module clocks.
 */
`timescale 1ns/1ns
`default_nettype none

module uesf_sync (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire uesf_pkg::uesf_flags_t i_async,
    output var uesf_pkg::uesf_flags_t o_sync
);
    import uesf_pkg::*;

    uesf_flags_t meta_r;

    // First stage is read only by the second stage.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= `UESF_FLAGS_RST;
            o_sync <= `UESF_FLAGS_RST;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

`default_nettype wire

// ===== design/uesf_turn_timer.sv
/*
 * Bus turnaround watchdog: counts idle module clocks after an end-of-packet.
 * Assumes synchronised end-of-packet and response-start levels, one clock wide pulses
 * produced by the caller.
 */
`timescale 1ns/1ns
`default_nettype none

module uesf_turn_timer (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_eop,
    input wire logic i_resp,
    output logic o_timeout
);
    import uesf_pkg::*;

    uesf_turn_t state_r;
    uesf_turn_t state_nxt;
    uesf_cnt_t cnt_r;
    uesf_cnt_t cnt_nxt;
    wire logic over_limit;

    // The limit counts as exceeded as soon as the count reaches sixteen bit times of clocks.
    assign over_limit = (cnt_r >= uesf_cnt_t'(`UESF_TURN_LIMIT));

    // Next state: arm on end-of-packet, disarm on response, fire once when idle too long.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            UESF_T_IDLE: begin
                cnt_nxt = `UESF_CNT_ZERO;
                if (i_eop) begin
                    state_nxt = UESF_T_WAIT;
                end
            end
            UESF_T_WAIT: begin
                if (i_resp) begin
                    state_nxt = UESF_T_IDLE;
                end else if (over_limit) begin
                    state_nxt = UESF_T_DONE;
                end else begin
                    cnt_nxt = cnt_r + `UESF_CNT_ONE;
                end
            end
            UESF_T_DONE: begin
                state_nxt = UESF_T_IDLE;
            end
            default: begin
                state_nxt = UESF_T_IDLE;
            end
        endcase
    end

    // State and counter registers; timeout pulses for one clock.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= UESF_T_IDLE;
            cnt_r <= `UESF_CNT_ZERO;
            o_timeout <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            o_timeout <= (state_r == UESF_T_WAIT) && !i_resp && over_limit;
        end
    end
endmodule

`default_nettype wire

// ===== design/uesf_top.sv
/*
 * USB error status flag block: sticky error flags set by the USB engine, cleared by
 * software writing ones over APB, with a mask and a level interrupt output.
 * Assumes event inputs arrive asynchronously as levels held at least two module clocks,
 * and an APB master on the module clock.
 */
`timescale 1ns/1ns
`default_nettype none

`include "uesf_consts.svh"

// Behaviour
// - Bit 7 sets on a packet rejected for a bit stuffing violation.
// - Bit 6 sets on an invalid descriptor table base or buffer address.
// - Bit 5 sets when a memory bus grant comes too late, overflow or underflow.
// - Bit 5 also sets when a receive buffer is too small, truncating.
// - Bit 4 sets after more than 16 idle bit times past end-of-packet.
// - Bit 3 sets when a data field is not a whole number of bytes.
// - Bit 2 sets and the data packet is rejected on 16-bit CRC failure.
// - In device mode bit 1 sets and token is rejected on 5-bit CRC failure.
// - In host mode bit 1 sets on activity while the frame counter is zero.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - Bits 31 to 8 read zero; all flags are zero after reset.
module uesf_top (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`UESF_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_host_mode,
    input wire logic i_bit_stuff_err,
    input wire logic i_bus_matrix_err,
    input wire logic i_grant_late,
    input wire logic i_rx_truncated,
    input wire logic i_eop,
    input wire logic i_resp_start,
    input wire logic i_byte_align_err,
    input wire logic i_data_crc_err,
    input wire logic i_token_crc_err,
    input wire logic i_link_active,
    input wire logic i_sof_zero,
    input wire logic i_pid_err,
    output logic o_data_reject,
    output logic o_token_reject,
    output logic o_irq
);
    import uesf_pkg::*;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************

    uesf_flags_t raw_a;
    uesf_flags_t raw_s;
    uesf_flags_t aux_a;
    uesf_flags_t aux_s;
    uesf_flags_t raw_d_r;
    uesf_flags_t aux_d_r;
    uesf_flags_t rise;
    uesf_flags_t aux_rise;

    // Primary event levels, one per flag position where possible.
    assign raw_a[`UESF_BIT_BIT_STUFF] = i_bit_stuff_err;
    assign raw_a[`UESF_BIT_BUS_MATRIX] = i_bus_matrix_err;
    assign raw_a[`UESF_BIT_MEM_ACCESS] = i_grant_late;
    assign raw_a[`UESF_BIT_TURNAROUND] = i_eop;
    assign raw_a[`UESF_BIT_BYTE_ALIGN] = i_byte_align_err;
    assign raw_a[`UESF_BIT_DATA_CRC] = i_data_crc_err;
    assign raw_a[`UESF_BIT_TOKEN_EOF] = i_token_crc_err;
    assign raw_a[`UESF_BIT_PID] = i_pid_err;

    // Secondary levels; unused lanes are tied low.
    assign aux_a[`UESF_BIT_BIT_STUFF] = 1'b0;
    assign aux_a[`UESF_BIT_BUS_MATRIX] = 1'b0;
    assign aux_a[`UESF_BIT_MEM_ACCESS] = i_rx_truncated;
    assign aux_a[`UESF_BIT_TURNAROUND] = i_resp_start;
    assign aux_a[`UESF_BIT_BYTE_ALIGN] = i_host_mode;
    assign aux_a[`UESF_BIT_DATA_CRC] = i_link_active;
    assign aux_a[`UESF_BIT_TOKEN_EOF] = i_sof_zero;
    assign aux_a[`UESF_BIT_PID] = 1'b0;

    uesf_sync u_sync_raw (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(raw_a),
        .o_sync(raw_s)
    );

    uesf_sync u_sync_aux (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(aux_a),
        .o_sync(aux_s)
    );

    // Delayed copies for rising-edge detection on synchronised levels.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            raw_d_r <= `UESF_FLAGS_RST;
            aux_d_r <= `UESF_FLAGS_RST;
        end else begin
            raw_d_r <= raw_s;
            aux_d_r <= aux_s;
        end
    end

    assign rise = raw_s & ~raw_d_r;
    assign aux_rise = aux_s & ~aux_d_r;

    // ****************************************************************
    // Event decode
    // ****************************************************************

    wire logic host_s;
    wire logic eof_cond;
    wire logic eof_d;
    wire logic turn_timeout;
    wire logic data_crc_ev;
    wire logic token_crc_ev;
    uesf_flags_t set_ev;
    logic eof_cond_d_r;

    assign host_s = aux_s[`UESF_BIT_BYTE_ALIGN];
    assign eof_d = eof_cond_d_r;
    // Activity while the frame counter sits at zero, host mode only.
    assign eof_cond = host_s && aux_s[`UESF_BIT_DATA_CRC] && aux_s[`UESF_BIT_TOKEN_EOF];
    assign data_crc_ev = rise[`UESF_BIT_DATA_CRC];
    assign token_crc_ev = rise[`UESF_BIT_TOKEN_EOF] && !host_s;

    // Edge register for the end-of-frame condition so it sets once per occurrence.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            eof_cond_d_r <= 1'b0;
        end else begin
            eof_cond_d_r <= eof_cond;
        end
    end

    uesf_turn_timer u_turn (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_eop(rise[`UESF_BIT_TURNAROUND]),
        .i_resp(aux_rise[`UESF_BIT_TURNAROUND]),
        .o_timeout(turn_timeout)
    );

    // Per-flag set conditions.
    assign set_ev[`UESF_BIT_BIT_STUFF] = rise[`UESF_BIT_BIT_STUFF];
    assign set_ev[`UESF_BIT_BUS_MATRIX] = rise[`UESF_BIT_BUS_MATRIX];
    // Late grant or truncated receive both flag a memory access error.
    assign set_ev[`UESF_BIT_MEM_ACCESS] = rise[`UESF_BIT_MEM_ACCESS]
        || aux_rise[`UESF_BIT_MEM_ACCESS];
    assign set_ev[`UESF_BIT_TURNAROUND] = turn_timeout;
    assign set_ev[`UESF_BIT_BYTE_ALIGN] = rise[`UESF_BIT_BYTE_ALIGN];
    assign set_ev[`UESF_BIT_DATA_CRC] = data_crc_ev;
    // Bit 1 is shared: token check in device mode, frame end in host mode.
    assign set_ev[`UESF_BIT_TOKEN_EOF] = token_crc_ev
        || (eof_cond && !eof_d);
    assign set_ev[`UESF_BIT_PID] = rise[`UESF_BIT_PID];

    // ****************************************************************
    // APB slave
    // ****************************************************************

    wire logic acc;
    wire logic wr;
    wire logic rd;
    wire logic hit_status;
    wire logic hit_mask;
    wire logic hit_raw;
    wire logic mapped;
    wire logic lane0;
    uesf_flags_t clr;
    uesf_flags_t flags_r;
    uesf_flags_t flags_nxt;
    uesf_flags_t mask_r;
    uesf_flags_t mask_nxt;
    logic [31:0] rdata;

    // Address match helper shared by all decodes.
    function automatic logic uesf_hit(input logic [`UESF_ADDR_W-1:0] a,
                                      input logic [`UESF_ADDR_W-1:0] off);
        uesf_hit = (a == off);
    endfunction

    // The slave answers in the second access cycle, after one wait state; pready is registered.
    assign acc = i_psel && i_penable && !o_pready;
    assign wr = acc && i_pwrite;
    assign rd = acc && !i_pwrite;
    assign hit_status = uesf_hit(i_paddr, `UESF_OFF_STATUS);
    assign hit_mask = uesf_hit(i_paddr, `UESF_OFF_MASK);
    assign hit_raw = uesf_hit(i_paddr, `UESF_OFF_EVENT_RAW);
    assign mapped = hit_status || hit_mask || hit_raw;
    assign lane0 = i_pstrb[0];

    // Write-one-to-clear mask from the low byte lane.
    assign clr = (wr && hit_status && lane0) ? i_pwdata[`UESF_NFLAGS-1:0]
                                             : `UESF_FLAGS_RST;
    // Hold until cleared; a set in the same cycle overrides the clear.
    assign flags_nxt = (flags_r & ~clr) | set_ev;
    assign mask_nxt = (wr && hit_mask && lane0) ? i_pwdata[`UESF_NFLAGS-1:0] : mask_r;

    // Read mux; upper bits always return zero.
    assign rdata = hit_status ? {24'h00_0000, flags_r} :
                   hit_mask ? {24'h00_0000, mask_r} :
                   hit_raw ? {24'h00_0000, raw_s} :
                   `UESF_ZERO32;

    // Flag and mask registers.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_r <= `UESF_FLAGS_RST;
            mask_r <= `UESF_MASK_RST;
        end else begin
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Bus answer registers.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= `UESF_ZERO32;
        end else begin
            o_pready <= acc;
            o_pslverr <= acc && !mapped;
            o_prdata <= rd ? rdata : `UESF_ZERO32;
        end
    end

    // ****************************************************************
    // Outputs to the USB engine and interrupt
    // ****************************************************************

    // Reject strobes and interrupt level, all registered.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data_reject <= 1'b0;
            o_token_reject <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_data_reject <= data_crc_ev;
            o_token_reject <= token_crc_ev;
            o_irq <= |(flags_nxt & mask_nxt);
        end
    end
endmodule

`default_nettype wire

// ===== tb/uesf_checker.sv
/*
 * Port checker of the USB error status flag block.
 * Assumes it is bound into the top module and that the constants header is on the path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "uesf_consts.svh"
module uesf_checker (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`UESF_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_host_mode,
    input wire logic i_data_crc_err,
    input wire logic i_token_crc_err,
    input wire logic o_data_reject,
    input wire logic o_token_reject,
    input wire logic o_irq
);
    // ************************************************************
    // Relations between the block's ports over time
    // ************************************************************
    // Every check runs on the module clock and rests while reset is low.
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    pready_time_a: assert property (($rose(i_penable) && i_psel) |=> o_pready)
        else $error("ready did not follow the first access cycle");
    pready_once_a: assert property (o_pready |=> !o_pready)
        else $error("ready stood longer than one cycle");
    upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h00_0000)
        else $error("upper read bits were not zero");
    slverr_pair_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
        else $error("error response without ready or with data");
    reset_quiet_a: assert property (!$past(i_rstn) |-> !o_irq && !o_pready)
        else $error("outputs active right after reset");
    data_reject_a: assert property ($rose(i_data_crc_err) |-> ##[1:5] o_data_reject)
        else $error("data reject missing after a data check event");
    reject_once_a: assert property (o_data_reject |=> !o_data_reject)
        else $error("data reject longer than one cycle");
    token_reject_a: assert property (($rose(i_token_crc_err) && !i_host_mode
        && !$past(i_host_mode, 4)) |-> ##[1:5] o_token_reject)
        else $error("token reject missing in device mode");
    host_noreject_a: assert property ((i_host_mode && $past(i_host_mode, 4))
        |-> !o_token_reject)
        else $error("token reject in host mode");
endmodule
`default_nettype wire

// ===== tb/uesf_usb_model.sv
/*
 * Model of the USB engine that raises the block's event lines.
 * Assumes one-cycle requests from the bench, at least five cycles apart per line.
 */
`timescale 1ns/1ns
`default_nettype none
module uesf_usb_model (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [11:0] i_req,
    output logic [11:0] o_lines
);
    // ************************************************************
    // Event line stretcher
    // ************************************************************
    logic [11:0] hold1_r;
    logic [11:0] hold2_r;
    // A one-cycle request becomes a three-cycle level, long enough for the synchroniser.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold1_r <= 12'h000;
            hold2_r <= 12'h000;
        end else begin
            hold1_r <= i_req;
            hold2_r <= hold1_r;
        end
    end
    // Lines are high from the request through the two held cycles.
    assign o_lines = i_req | hold1_r | hold2_r;
endmodule
`default_nettype wire

// ===== tb/uesf_top_bench.sv
/*
 * Self-checking bench of the USB error status flag block over APB.
 * Assumes the design files, the usb model and the checker are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "uesf_consts.svh"
module uesf_top_bench;
    // ************************************************************
    // Clock, reset, stimulus and the block
    // ************************************************************
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, host = 1'b0;
    logic [11:0] addr = 12'h000, req = 12'h000, ln;
    logic [31:0] wdata = 32'h0000_0000, prdata, rd;
    logic [3:0] strb = 4'hf;
    logic pready, pslverr, drej, trej, irq, er;
    int fail_count = 0, tests_run = 0;
    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;
    uesf_usb_model MODEL (.i_mclk(clk), .i_rstn(rstn), .i_req(req), .o_lines(ln));
    uesf_top DUT (.i_mclk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .i_pstrb(strb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_host_mode(host),
        .i_bit_stuff_err(ln[7]), .i_bus_matrix_err(ln[6]), .i_grant_late(ln[5]),
        .i_rx_truncated(ln[8]), .i_eop(ln[4]), .i_resp_start(ln[9]),
        .i_byte_align_err(ln[3]), .i_data_crc_err(ln[2]), .i_token_crc_err(ln[1]),
        .i_link_active(ln[10]), .i_sof_zero(ln[11]), .i_pid_err(ln[0]),
        .o_data_reject(drej), .o_token_reject(trej), .o_irq(irq));
    // Prints the counts and the verdict, then stops.
    task final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    // One APB transfer; it waits for ready under a bound, then leaves one idle cycle.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwr <= w; addr <= a; wdata <= d;
        @(posedge clk) pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin check("ready wait", 0, 1); final_report(); end
            @(posedge clk);
        end
        rd = prdata; er = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, rd, x);
    endtask
    task ev(input logic [11:0] m, input int n);
        req <= m;
        @(posedge clk) req <= 12'h000;
        repeat (n) @(posedge clk);
    endtask
    // Every flag sets on its event, survives a zero write, clears on a one, and drives irq.
    task t_flags;
        int f;
        apb(1'b1, `UESF_OFF_MASK, 32'h0000_00ff);
        for (int k = 0; k < 9; k++) begin
            f = (k == 8) ? 5 : k;
            ev(12'h001 << k, (k == 4) ? 100 : 8);
            if (k == 4) rdchk(`UESF_OFF_STATUS, 0, "early timeout");
            if (k == 4) repeat (40) @(posedge clk);
            rdchk(`UESF_OFF_STATUS, 32'h1 << f, "flag set");
            check("irq on", irq, 1);
            apb(1'b1, `UESF_OFF_STATUS, 32'h0000_0000);
            rdchk(`UESF_OFF_STATUS, 32'h1 << f, "flag kept");
            apb(1'b1, `UESF_OFF_STATUS, 32'h1 << f);
            rdchk(`UESF_OFF_STATUS, 0, "flag cleared");
            check("irq off", irq, 0);
        end
    endtask
    // A response soon after end-of-packet disarms the timeout; host mode reroutes bit 1.
    task t_modes;
        ev(12'h010, 20);
        ev(12'h200, 150);
        rdchk(`UESF_OFF_STATUS, 0, "disarmed timeout");
        host <= 1'b1;
        ev(12'h002, 10);
        rdchk(`UESF_OFF_STATUS, 0, "token in host");
        ev(12'hc00, 10);
        rdchk(`UESF_OFF_STATUS, 32'h0000_0002, "frame end");
        host <= 1'b0;
        apb(1'b1, `UESF_OFF_STATUS, 32'h0000_0002);
    endtask
    // Masked events leave irq low; refused writes and unmapped places change nothing.
    task t_refuse;
        apb(1'b1, `UESF_OFF_MASK, 32'h0000_0000);
        ev(12'h004, 8);
        check("masked irq", irq, 0);
        strb <= 4'he;
        apb(1'b1, `UESF_OFF_STATUS, 32'h0000_00ff);
        strb <= 4'hf;
        rdchk(`UESF_OFF_STATUS, 32'h0000_0004, "strobe refused");
        apb(1'b1, 12'h010, 32'h0000_00ff);
        check("unmapped error", er, 1);
        rdchk(12'h00c, 0, "unmapped read");
        check("unmapped read error", er, 1);
        rdchk(`UESF_OFF_STATUS, 32'h0000_0004, "unmapped write");
    endtask
    // A reset in mid-run returns every flag and the mask to zero.
    task t_reset;
        rdchk(`UESF_OFF_STATUS, 0, "status reset");
        rdchk(`UESF_OFF_MASK, 0, "mask reset");
        rdchk(`UESF_OFF_EVENT_RAW, 0, "raw idle");
        check("irq reset", irq, 0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_flags();
        t_modes();
        t_refuse();
        @(posedge clk) rstn <= 1'b0;
        @(posedge clk) rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        final_report();
    end
endmodule
bind uesf_top uesf_checker CHK (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_host_mode(i_host_mode),
    .i_data_crc_err(i_data_crc_err), .i_token_crc_err(i_token_crc_err),
    .o_data_reject(o_data_reject), .o_token_reject(o_token_reject), .o_irq(o_irq));
`default_nettype wire
